// *** frep_char_check.sv ***
// Per-port character checker: start, even parity and stop over 11 bits
`timescale 1ns/100ps
module frep_char_check (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Synchronised line and bit period
  input wire logic line_in,
  input wire logic [frep_pkg::BIT_W-1:0] bit_len,
  // Results as one-cycle pulses, busy as a level while a character is read
  output logic char_ok,
  output logic char_err,
  output logic busy
);
  logic [frep_pkg::BIT_W-1:0] cnt;
  logic [3:0] idx;
  logic [10:0] sh;
  logic line_d;

  // Sample at bit centres after a falling start edge
  always_ff @(posedge clk_sys) begin
    char_ok <= 1'b0;
    char_err <= 1'b0;
    line_d <= line_in;
    if (!rst_n || bit_len == '0) begin
      busy <= 1'b0;
      cnt <= '0;
      idx <= 4'h0;
      sh <= '0;
    end else if (!busy) begin
      if (line_d && !line_in) begin
        busy <= 1'b1;
        cnt <= bit_len >> 1;
        idx <= 4'h0;
      end
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      cnt <= bit_len - 1'b1;
      sh <= {line_in, sh[10:1]};
      if (idx == 4'(frep_pkg::CHAR_BITS - 1)) begin
        busy <= 1'b0;
        // Start low, stop high, even parity over data and parity
        if (!sh[1] && line_in && !(^sh[10:2])) begin
          char_ok <= 1'b1;
        end else begin
          char_err <= 1'b1;
        end
      end else begin
        idx <= idx + 4'h1;
      end
    end
  end
endmodule : frep_char_check

// *** frep_checker.sv ***
// Bus handshake, latency and fault-contact checker for the repeater
`timescale 1ns/100ps
module frep_checker #(
  parameter int DLY_DEPTH = 4096
) (
  // Clock, reset and register bus
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Line side
  input wire logic rx_b,
  input wire logic tx_a,
  input wire logic tx_a_oe,
  input wire logic tx_b_oe,
  input wire logic rail_in,
  input wire logic rail_oe,
  input wire logic fault_closed
);
  logic wr_ok, clr_now, dir;
  logic [3:0] spd;
  logic [2:0] clr;
  // Accepted control writes, so mode and clears are known here
  assign wr_ok = avs_write && !avs_waitrequest && avs_address == frep_pkg::REG_CTRL;
  assign clr_now = wr_ok && avs_writedata[frep_pkg::CTRL_ERRCLR_BIT];
  // Clear history covers a register stage or two inside the design
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dir <= 1'b0;
      spd <= 4'h0;
      clr <= 3'h0;
    end else begin
      clr <= {clr[1:0], clr_now};
      if (wr_ok) begin
        dir <= avs_writedata[4];
        spd <= avs_writedata[3:0];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_quiet; ##20 tx_a ##10 tx_a; endsequence
  property p_ans; s_req |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("No answer one cycle after request");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("Waitrequest low longer than one cycle");
  property p_spur; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_spur: assert property (p_spur) else $error("Answer without a request");
  property p_dir; dir && spd == 4'h1 && $fell(rx_b) |-> ##[18:40] !tx_a; endproperty
  a_dir: assert property (p_dir) else $error("Pass-through lag not one bit");
  property p_filt; !dir && spd == 4'h1 && $fell(rx_b) && !tx_a_oe |-> s_quiet; endproperty
  a_filt: assert property (p_filt) else $error("Filtering output too early");
  property p_hold; !fault_closed && clr == 3'h0 && !clr_now |=> !fault_closed; endproperty
  a_hold: assert property (p_hold) else $error("Fault contact closed uncleared");
  property p_idle; !tx_a_oe |-> tx_a; endproperty
  a_idle: assert property (p_idle) else $error("Port A data not idle high");
  property p_excl; !(tx_a_oe && tx_b_oe && rail_oe); endproperty
  a_excl: assert property (p_excl) else $error("Source side driven as well");
  property p_rail; $fell(rail_in) && !tx_a_oe && !tx_b_oe |-> ##[3:10] !tx_a; endproperty
  a_rail: assert property (p_rail) else $error("Rail data delayed on port A");
endmodule : frep_checker
bind frep_repeater frep_checker #(.DLY_DEPTH(DLY_DEPTH)) frep_checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .rx_b(rx_b), .tx_a(tx_a), .tx_a_oe(tx_a_oe), .tx_b_oe(tx_b_oe),
  .rail_in(rail_in), .rail_oe(rail_oe), .fault_closed(fault_closed));

// *** frep_pkg.sv ***
// Package for the fieldbus repeater mode and speed select block
package frep_pkg;
  // Speed switch codes, switch 1 is the msb
  localparam logic [3:0] SPD_AUTO = 4'h0;
  localparam logic [3:0] SPD_12000 = 4'h1;
  localparam logic [3:0] SPD_6000 = 4'h2;
  localparam logic [3:0] SPD_3000 = 4'h3;
  localparam logic [3:0] SPD_1500 = 4'h4;
  localparam logic [3:0] SPD_500 = 4'h5;
  localparam logic [3:0] SPD_187K5 = 4'h6;
  localparam logic [3:0] SPD_93K75 = 4'h7;
  localparam logic [3:0] SPD_45K45 = 4'h8;
  localparam logic [3:0] SPD_19K2 = 4'h9;
  localparam logic [3:0] SPD_9K6 = 4'ha;
  // Clock rate and derived bit periods in clk_sys cycles
  localparam int CLK_KHZ = 250000;
  localparam int BIT_W = 20;
  // Latencies and character length in bit times
  localparam int LAT_FILTER_BITS = 11;
  localparam int LAT_DIRECT_BITS = 1;
  localparam int CHAR_BITS = 11;
  // Register map, 32-bit words at byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ERRCNT = 4'h8;
  // Control register fields
  localparam int CTRL_SPD_LSB = 0;
  localparam int CTRL_MODE_BIT = 4;
  localparam int CTRL_SW6_BIT = 5;
  localparam int CTRL_ERRCLR_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Mode choice
  typedef enum logic {FREP_FILTER, FREP_DIRECT} frep_mode_t;
  // Configuration carried as one bundle
  typedef struct packed {
    logic [3:0] speed;
    frep_mode_t mode;
  } frep_cfg_t;
  // Bit period in cycles for each speed code, 0 for auto
  function automatic logic [BIT_W-1:0] bit_cycles(input logic [3:0] code);
    case (code)
      SPD_12000: bit_cycles = BIT_W'(CLK_KHZ / 12000);
      SPD_6000: bit_cycles = BIT_W'(CLK_KHZ / 6000);
      SPD_3000: bit_cycles = BIT_W'(CLK_KHZ / 3000);
      SPD_1500: bit_cycles = BIT_W'(CLK_KHZ / 1500);
      SPD_500: bit_cycles = BIT_W'(CLK_KHZ / 500);
      SPD_187K5: bit_cycles = BIT_W'((CLK_KHZ * 2) / 375);
      SPD_93K75: bit_cycles = BIT_W'((CLK_KHZ * 4) / 375);
      SPD_45K45: bit_cycles = BIT_W'((CLK_KHZ * 100) / 4545);
      SPD_19K2: bit_cycles = BIT_W'((CLK_KHZ * 10) / 192);
      SPD_9K6: bit_cycles = BIT_W'((CLK_KHZ * 10) / 96);
      default: bit_cycles = '0;
    endcase
  endfunction : bit_cycles
endpackage : frep_pkg

// *** frep_repeater.sv ***
// Two-port repeater core with mode and speed select over Avalon-MM
// Functional notes
// - Four speed switches, switch 1 msb, code 0 auto, 1..10 fixed rates.
// - All switches off means automatic rate detection and filtering mode.
// - Switch 5 on gives pass-through, off gives filtering.
// - Filtering mode checks each telegram from port A or B and drops damaged ones; rail telegrams pass unchecked.
// - Filtering mode delays output by 11 bit times, capped at 4095 cycles (500 kbit/s and below).
// - Pass-through delays by 1 bit time, capped at 4095 cycles (45.45 kbit/s and below), no filtering.
// - Rail distribution adds no latency beyond the front port delay.
// - Same latency for telegrams arriving on port A or port B.
// - Fault contact opens on a transmission error at either port.
`timescale 1ns/100ps
module frep_repeater #(
  parameter int DLY_DEPTH = 4096
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Front port A and B receive lines
  input wire logic rx_a,
  input wire logic rx_b,
  // Transmit data and drive enables
  output logic tx_a,
  output logic tx_a_oe,
  output logic tx_b,
  output logic tx_b_oe,
  // Rail connector
  input wire logic rail_in,
  output logic rail_out,
  output logic rail_oe,
  // Fault contact, high while closed
  output logic fault_closed
);
  logic [31:0] ctrl;
  frep_pkg::frep_cfg_t cfg;
  logic [2:0] sa;
  logic [2:0] sb;
  logic [2:0] sr;
  logic ln_a;
  logic ln_b;
  logic ln_r;
  logic [frep_pkg::BIT_W-1:0] auto_len;
  logic [frep_pkg::BIT_W-1:0] edge_cnt;
  logic [frep_pkg::BIT_W-1:0] bit_len;
  logic ok_a, err_a, busy_a, ok_b, err_b, busy_b;
  logic [1:0] src;
  logic [frep_pkg::BIT_W-1:0] idle_cnt;
  logic [DLY_DEPTH-1:0] dly;
  logic [frep_pkg::BIT_W+3:0] lat;
  logic [frep_pkg::BIT_W+3:0] lat_cnt;
  logic out_bit;
  logic drop;
  logic err_a_st, err_b_st;
  logic [15:0] err_cnt;
  logic active;
  logic avs_waitrequest_q;
  logic clr_err;

  // Switch 5 picks mode, switch 6 bit ignored
  assign cfg = '{speed: ctrl[frep_pkg::CTRL_SPD_LSB +: 4],
    mode: ctrl[frep_pkg::CTRL_MODE_BIT] ? frep_pkg::FREP_DIRECT : frep_pkg::FREP_FILTER};

  // Pin synchronisers, change accepted when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sa <= 3'h7;
      sb <= 3'h7;
      sr <= 3'h7;
      ln_a <= 1'b1;
      ln_b <= 1'b1;
      ln_r <= 1'b1;
    end else begin
      sa <= {sa[1:0], rx_a};
      sb <= {sb[1:0], rx_b};
      sr <= {sr[1:0], rail_in};
      if (sa[1] == sa[2]) ln_a <= sa[2];
      if (sb[1] == sb[2]) ln_b <= sb[2];
      if (sr[1] == sr[2]) ln_r <= sr[2];
    end
  end

  // Avalon slave, one wait cycle then answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl <= frep_pkg::CTRL_RESET;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= 1'b1;
      // Write lands on the edge at which the master sees waitrequest low
      if (avs_write && !avs_waitrequest && avs_address == frep_pkg::REG_CTRL) begin
        ctrl <= avs_writedata & 32'h0000_003f;
      end
      if ((avs_read || avs_write) && avs_waitrequest && !avs_waitrequest_q) begin
        avs_waitrequest <= 1'b0;
        unique case (avs_address)
          frep_pkg::REG_CTRL: avs_readdata <= ctrl;
          frep_pkg::REG_STATUS: avs_readdata <= {24'h0, bit_len == '0,
            cfg.mode == frep_pkg::FREP_DIRECT, busy_b, busy_a, active,
            err_b_st, err_a_st, fault_closed};
          frep_pkg::REG_ERRCNT: avs_readdata <= {16'h0, err_cnt};
          default: avs_readdata <= frep_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end

  // Suppresses a second answer while the master releases
  always_ff @(posedge clk_sys) begin
    if (!rst_n) avs_waitrequest_q <= 1'b0;
    else avs_waitrequest_q <= !avs_waitrequest;
  end

  // Fixed rate from code, auto measures shortest pulse between edges on port A or B
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      auto_len <= '0;
      edge_cnt <= '0;
    end else begin
      edge_cnt <= (ln_a != sa[2] || ln_b != sb[2]) ? '0 : edge_cnt + 1'b1;
      if ((ln_a != sa[2] || ln_b != sb[2]) && edge_cnt > 1 &&
          (auto_len == '0 || edge_cnt < auto_len)) begin
        auto_len <= edge_cnt + 1'b1;
      end
    end
  end
  assign bit_len = (cfg.speed == frep_pkg::SPD_AUTO) ? auto_len : frep_pkg::bit_cycles(cfg.speed);

  // Character checkers for the two front ports
  frep_char_check u_chk_a (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(ln_a),
    .bit_len(bit_len), .char_ok(ok_a), .char_err(err_a), .busy(busy_a));
  frep_char_check u_chk_b (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(ln_b),
    .bit_len(bit_len), .char_ok(ok_b), .char_err(err_b), .busy(busy_b));

  // Source is whichever port goes low first, held until line idle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      src <= 2'h0;
      idle_cnt <= '0;
    end else if (src == 2'h0) begin
      if (!ln_a) src <= 2'h1;
      else if (!ln_b) src <= 2'h2;
      else if (!ln_r) src <= 2'h3;
      idle_cnt <= '0;
    end else begin
      idle_cnt <= (src == 2'h1 ? ln_a : src == 2'h2 ? ln_b : ln_r) ? idle_cnt + 1'b1 : '0;
      if (bit_len != '0 && idle_cnt > (bit_len << 5) + lat[frep_pkg::BIT_W-1:0]) src <= 2'h0;
    end
  end
  assign active = src != 2'h0;

  // Latency in cycles from mode, shift line carries the bits
  assign lat = (cfg.mode == frep_pkg::FREP_FILTER) ?
    (frep_pkg::BIT_W+4)'(bit_len * frep_pkg::LAT_FILTER_BITS) :
    (frep_pkg::BIT_W+4)'(bit_len * frep_pkg::LAT_DIRECT_BITS);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dly <= '1;
    end else begin
      // Rail input taken without added front port delay path
      dly <= {dly[DLY_DEPTH-2:0], src == 2'h1 ? ln_a : src == 2'h2 ? ln_b : 1'b1};
    end
  end
  assign lat_cnt = (lat >= DLY_DEPTH) ? (frep_pkg::BIT_W+4)'(DLY_DEPTH - 1) : lat;
  assign out_bit = (src == 2'h3) ? ln_r : dly[lat_cnt[11:0]];

  // Damaged character in filter mode drops rest of telegram
  always_ff @(posedge clk_sys) begin
    if (!rst_n || src == 2'h0) drop <= 1'b0;
    else if (cfg.mode == frep_pkg::FREP_FILTER &&
             ((src == 2'h1 && err_a) || (src == 2'h2 && err_b))) drop <= 1'b1;
  end

  // Drive every output except the source's, idle high otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_a <= 1'b1;
      tx_b <= 1'b1;
      rail_out <= 1'b1;
      tx_a_oe <= 1'b0;
      tx_b_oe <= 1'b0;
      rail_oe <= 1'b0;
    end else begin
      // Undriven outputs rest high so the source never sees its own echo
      tx_a <= (active && src != 2'h1 && !drop) ? out_bit : 1'b1;
      tx_b <= (active && src != 2'h2 && !drop) ? out_bit : 1'b1;
      rail_out <= (active && src != 2'h3 && !drop) ? out_bit : 1'b1;
      tx_a_oe <= active && src != 2'h1 && !drop;
      tx_b_oe <= active && src != 2'h2 && !drop;
      rail_oe <= active && src != 2'h3 && !drop;
    end
  end

  // Error flags open the contact, cleared by control write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      err_a_st <= 1'b0;
      err_b_st <= 1'b0;
      err_cnt <= '0;
      fault_closed <= 1'b1;
    end else begin
      if (err_a) err_a_st <= 1'b1;
      else if (clr_err) err_a_st <= 1'b0;
      if (err_b) err_b_st <= 1'b1;
      else if (clr_err) err_b_st <= 1'b0;
      if ((err_a || err_b) && err_cnt != 16'hffff) err_cnt <= err_cnt + 16'h1;
      fault_closed <= !(err_a || err_b || err_a_st || err_b_st);
    end
  end

  // Clear pulse from a control write with the clear bit set
  assign clr_err = avs_write && !avs_waitrequest &&
    avs_address == frep_pkg::REG_CTRL && avs_writedata[frep_pkg::CTRL_ERRCLR_BIT];
endmodule : frep_repeater

// *** frep_station.sv ***
// Fieldbus station model driving one receive line with characters
`timescale 1ns/100ps
module frep_station #(
  parameter int BIT = 20
) (
  // Clock
  input wire logic clk_sys,
  // Line toward the repeater
  output logic line
);
  // Biased bus idles high between characters
  initial line = 1'b1;
  // Start, data lsb first, even parity, stop; bad flips the parity
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      line <= f[i];
      repeat (BIT - 1) @(posedge clk_sys);
    end
  endtask : send
endmodule : frep_station

// *** testbench.sv ***
// Self-checking testbench for the repeater core
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, v, m;
  logic avs_waitrequest, rx_a, rx_b, rx_r, tx_a, tx_a_oe, tx_b, tx_b_oe, fault_closed;
  logic rail_out, rail_oe;
  int low_r = 0;
  int n_a = 0;
  int n_b = 0;
  int fails = 0;
  int checks = 0;
  int seed = 15235;
  int low_a = 0;
  int low_b = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  frep_station sta_a (.clk_sys(clk_sys), .line(rx_a));
  frep_station sta_b (.clk_sys(clk_sys), .line(rx_b));
  // Neighbour repeater on the rail
  frep_station sta_r (.clk_sys(clk_sys), .line(rx_r));
  frep_repeater #(.DLY_DEPTH(4096)) frep_repeater_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_a(rx_a), .rx_b(rx_b), .tx_a(tx_a),
    .tx_a_oe(tx_a_oe), .tx_b(tx_b), .tx_b_oe(tx_b_oe), .rail_in(rx_r), .rail_out(rail_out),
    .rail_oe(rail_oe), .fault_closed(fault_closed));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Long enough for the 32-bit idle timeout plus lag, so another port may lead
  // Gap well above the 22-bit round trip a master allows per repeater
  task automatic settle;
    repeat (1200) @(posedge clk_sys);
  endtask : settle
  task automatic test_done;
    $display("Counts: %0d checks, %0d fails", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Read monitor takes the oldest note; also counts driven low cycles
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      m = msk_q.pop_front();
      chk(avs_readdata & m, exp_q.pop_front());
    end
    if (tx_a_oe && !tx_a)
      low_a++;
    if (tx_b_oe && !tx_b)
      low_b++;
    if (rail_oe && !rail_out)
      low_r++;
  end
  // Watchdog well above the roughly 7300-cycle sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0, 32'h11f);
    rd(4'h4, 32'h81, 32'hc1);
    bus(1'b1, 4'hc, 32'h1f);
    rd(4'hc, 32'h0, 32'hffffffff);
    rd(4'h0, 32'h0, 32'h1f);
    $display("Test reset and unmapped done");
    // every speed code, random mode and switch 6
    for (int c = 0; c <= 10; c++) begin
      v = ($random(seed) & 32'h30) | c;
      bus(1'b1, 4'h0, v);
      rd(4'h0, v & 32'h1f, 32'h1f);
      rd(4'h4, {24'h0, c == 0, v[4], 6'h0}, 32'hc0);
    end
    $display("Test switch codes done");
    bus(1'b1, 4'h0, 32'h1);
    sta_b.send(8'($random(seed)), 1'b0);
    settle;
    chk(32'(low_a > 0 && low_r > 0), 32'h1);
    sta_a.send(8'($random(seed)), 1'b1);
    settle;
    chk(32'(low_b), 32'h0);
    rd(4'h4, 32'h2, 32'h3);
    rd(4'h8, 32'h1, 32'hffff);
    bus(1'b1, 4'h0, 32'h101);
    rd(4'h4, 32'h1, 32'h3);
    $display("Test filtering done");
    // pass-through forwards even a damaged character
    bus(1'b1, 4'h0, 32'h11);
    sta_a.send(8'($random(seed)), 1'b1);
    settle;
    chk(32'(low_b > 0), 32'h1);
    n_a = low_a;
    sta_b.send(8'($random(seed)), 1'b0);
    settle;
    chk(32'(low_a > n_a), 32'h1);
    $display("Test pass-through done");
    // rail traffic leaves on both front ports
    n_a = low_a;
    n_b = low_b;
    sta_r.send(8'($random(seed)), 1'b0);
    settle;
    chk(32'(low_a > n_a && low_b > n_b), 32'h1);
    // Automatic rate learnt from the traffic so far
    bus(1'b1, 4'h0, 32'h0);
    rd(4'h4, 32'h0, 32'h80);
    $display("Test rail and auto rate done");
    test_done;
  end
endmodule : testbench
